// file: iorat_pkg.sv
// iorat_pkg: region map, per-region access latencies, encodings and field widths
// assumes: a single core clock; peripheral and flash clocks are integer divisions of it
package iorat_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // widths
  localparam int IORAT_AW = 32;
  localparam int IORAT_DW = 32;
  localparam int IORAT_CW = 6;  // latency counter width
  localparam int IORAT_RW = 4;  // clock ratio width
  localparam int IORAT_WW = 3;  // port read wait count width
  localparam int IORAT_NREG = 22;
  localparam int IORAT_IW = 5;  // region index width

  //////////////////////////////////////////////////////////////////////////////
  // access size codes
  localparam logic [1:0] IORAT_SZ_8 = 2'h0;
  localparam logic [1:0] IORAT_SZ_16 = 2'h1;
  localparam logic [1:0] IORAT_SZ_32 = 2'h2;

  // reference clock codes, also the index into the tick vector
  localparam logic [1:0] IORAT_U_CORE = 2'h0;
  localparam logic [1:0] IORAT_U_PA = 2'h1;
  localparam logic [1:0] IORAT_U_PB = 2'h2;
  localparam logic [1:0] IORAT_U_FL = 2'h3;

  //////////////////////////////////////////////////////////////////////////////
  // region table, one entry per address range
  localparam logic [31:0] IORAT_LO [IORAT_NREG] = '{
    32'h4000_0000, 32'h4000_7000, 32'h4000_8000, 32'h4001_e000, 32'h4001_f000,
    32'h4008_2000, 32'h4009_7000, 32'h4009_d000, 32'h400d_4000, 32'h400e_0000,
    32'h400e_8000, 32'h4010_8000, 32'h4011_8000, 32'h4011_a000, 32'h4011_f000,
    32'h4016_9000, 32'h4017_0000, 32'h6400_0000, 32'h6400_0010, 32'h6400_0014,
    32'h6400_0804, 32'h407e_c000};
  localparam logic [31:0] IORAT_HI [IORAT_NREG] = '{
    32'h4000_6fff, 32'h4000_7fff, 32'h4001_cfff, 32'h4001_e5ff, 32'h4001_ffff,
    32'h4008_afff, 32'h4009_7fff, 32'h400d_0fff, 32'h400d_4fff, 32'h400e_0fff,
    32'h400e_8fff, 32'h4010_9fff, 32'h4011_8fff, 32'h4011_afff, 32'h4012_ffff,
    32'h4016_9fff, 32'h4017_1fff, 32'h6400_000f, 32'h6400_0013, 32'h6400_0037,
    32'h6400_0807, 32'h407f_efff};
  // read cycles, write cycles (at equal clocks; the longest figure)
  localparam logic [5:0] IORAT_RD [IORAT_NREG] = '{
    6'h04, 6'h04, 6'h04, 6'h06, 6'h05, 6'h05, 6'h04, 6'h05, 6'h04, 6'h05, 6'h07,
    6'h05, 6'h05, 6'h05, 6'h05, 6'h07, 6'h05, 6'h05, 6'h19, 6'h05, 6'h04, 6'h05};
  localparam logic [5:0] IORAT_WR [IORAT_NREG] = '{
    6'h03, 6'h05, 6'h03, 6'h05, 6'h04, 6'h04, 6'h03, 6'h04, 6'h03, 6'h04, 6'h04,
    6'h04, 6'h04, 6'h04, 6'h04, 6'h04, 6'h04, 6'h0e, 6'h06, 6'h0e, 6'h03, 6'h04};
  localparam logic [1:0] IORAT_UNIT [IORAT_NREG] = '{
    2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2,
    2'h1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h3};
  // regions whose end depends on the serial bus engine
  localparam logic [IORAT_NREG-1:0] IORAT_QSPI = 22'h0e_0000;

  //////////////////////////////////////////////////////////////////////////////
  // special regions and registers
  localparam logic [4:0] IORAT_IDX_PORT = 5'h04;
  localparam logic [4:0] IORAT_IDX_SCI = 5'h0c;
  localparam logic [4:0] IORAT_IDX_SPI = 5'h0d;
  localparam logic [31:0] IORAT_PFS_LO = 32'h4001_f800;
  localparam logic [31:0] IORAT_PFS_HI = 32'h4001_ffff;
  localparam logic [31:0] IORAT_PRC2_ADDR = 32'h4001_f0f8;
  localparam logic [11:0] IORAT_SPI_DATA_OFS = 12'h004;
  localparam logic [11:0] IORAT_SPI_CH_MASK = 12'h0fc;
  localparam logic [5:0] IORAT_WIDE_EXTRA = 6'h02;
  localparam logic [IORAT_RW-1:0] IORAT_RATIO_ONE = 4'h1;

  //////////////////////////////////////////////////////////////////////////////
  // bridge states, one-hot
  typedef enum logic [3:0] {
    IORAT_ST_IDLE = 4'b0001,
    IORAT_ST_COUNT = 4'b0010,
    IORAT_ST_QWAIT = 4'b0100,
    IORAT_ST_DONE = 4'b1000
  } iorat_state_t;

endpackage

// file: iorat_clk_div.sv
// iorat_clk_div: turns the core clock into a one-cycle enable at a divided rate
// assumes: ratio is static while accesses run; 0 is treated as 1
`timescale 1ns/1ns
module iorat_clk_div
  import iorat_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [IORAT_RW-1:0] ratio,
  output logic tick_r
);

  //////////////////////////////////////////////////////////////////////////////
  logic [IORAT_RW-1:0] cnt_r;
  logic [IORAT_RW-1:0] cnt_nxt;
  logic [IORAT_RW-1:0] last_w;
  logic wrap_w;

  // last count of a period; ratio of one fires every cycle
  assign last_w = (ratio <= IORAT_RATIO_ONE) ? '0 : ratio - IORAT_RATIO_ONE;
  assign wrap_w = (cnt_r >= last_w);
  assign cnt_nxt = wrap_w ? '0 : cnt_r + IORAT_RATIO_ONE;

  // free-running divider with registered enable
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
      tick_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      tick_r <= wrap_w;
    end
  end

endmodule

// file: iorat_bridge.sv
// iorat_bridge: stalls a bus master for the documented latency of each i/o region
// assumes: master holds its request until resp_valid_r and drops it the cycle after;
// peripherals present read data on periph_rdata by the end of the latency
//
// How it works
// - equal clocks give fixed sync cycles
// - faster core adds at least one peripheral cycle; bridge adds none, elapsed is count-1 to count periods
// - writes finish only after full listed count
// - contention from other masters stretches access
// - control region: 4 read, 3 write core
// - port region 5/4, pin function and second port control reads add wait count
// - event/rtc/watchdog region timed in clock b
// - async timer region 7/4 in clock b
// - pwm timer region 7/4 in clock a
// - flash registers timed in flash clock
// - fractional counts: truncate minimum, round maximum up
// - sci 16-bit registers take two more
// - spi 32-bit data access takes two more
// - quad spi waits serial bus, data 25 min
`timescale 1ns/1ns
module iorat_bridge
  import iorat_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [IORAT_AW-1:0] req_addr,
  input wire logic [1:0] req_size,
  input wire logic [IORAT_DW-1:0] req_wdata,
  input wire logic contend,
  input wire logic [IORAT_RW-1:0] peripheral_clock_a_ratio,
  input wire logic [IORAT_RW-1:0] peripheral_clock_b_ratio,
  input wire logic [IORAT_RW-1:0] flash_clock_ratio,
  input wire logic [IORAT_WW-1:0] port_read_wait_count,
  input wire logic qspi_done,
  input wire logic [IORAT_DW-1:0] periph_rdata,
  output logic resp_valid_r,
  output logic resp_err_r,
  output logic [IORAT_DW-1:0] resp_rdata_r,
  output logic busy_r,
  output logic periph_sel_r,
  output logic periph_write_r,
  output logic [IORAT_AW-1:0] periph_addr_r,
  output logic [1:0] periph_size_r,
  output logic [IORAT_DW-1:0] periph_wdata_r
);

  //////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [IORAT_IW:0] first_hit(input logic [IORAT_NREG-1:0] hv);
    logic [IORAT_IW:0] res;
    res = '0;
    for (int k = IORAT_NREG - 1; k >= 0; k--) begin
      if (hv[k]) begin
        res = {1'b1, k[IORAT_IW-1:0]};
      end
    end
    return res;
  endfunction

  function automatic logic in_range(input logic [31:0] a, input logic [31:0] lo,
                                    input logic [31:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // divided clock enables for the peripheral and flash clocks
  logic [3:0] tick_w;
  logic [IORAT_RW-1:0] ratio_w [3];

  assign ratio_w[0] = peripheral_clock_a_ratio;
  assign ratio_w[1] = peripheral_clock_b_ratio;
  assign ratio_w[2] = flash_clock_ratio;
  assign tick_w[0] = 1'b1; // core clock counts every cycle

  generate
    for (genvar g = 0; g < 3; g++) begin : g_div
      iorat_clk_div u_div (
        .clk(clk),
        .rst_n(rst_n),
        .ratio(ratio_w[g]),
        .tick_r(tick_w[g+1])
      );
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // region decode of the incoming address
  logic [IORAT_NREG-1:0] hit_w;
  logic [IORAT_IW:0] sel_w;
  logic [IORAT_IW-1:0] idx_w;
  logic mapped_w;

  generate
    for (genvar r = 0; r < IORAT_NREG; r++) begin : g_hit
      assign hit_w[r] = in_range(req_addr, IORAT_LO[r], IORAT_HI[r]);
    end
  endgenerate

  assign sel_w = first_hit(hit_w);
  assign mapped_w = sel_w[IORAT_IW];
  assign idx_w = sel_w[IORAT_IW-1:0];

  //////////////////////////////////////////////////////////////////////////////
  // latency of the request in cycles of its reference clock
  logic [5:0] base_w;
  logic [5:0] port_extra_w;
  logic [5:0] wide_extra_w;
  logic [5:0] load_w;
  logic port_slow_w;
  logic sci_wide_w;
  logic spi_wide_w;

  // writes use the full non-bufferable figure
  // regions in the control and port space run on the core clock
  assign base_w = req_write ? IORAT_WR[idx_w] : IORAT_RD[idx_w];
  // pin function and second port control reads stretch by the wait count
  assign port_slow_w = !req_write && (idx_w == IORAT_IDX_PORT) &&
                       (in_range(req_addr, IORAT_PFS_LO, IORAT_PFS_HI) ||
                        (req_addr == IORAT_PRC2_ADDR));
  assign port_extra_w = port_slow_w ? {3'h0, port_read_wait_count} : 6'h00;
  // sci 16-bit fifo/control accesses; 8-bit halves keep the region figure
  assign sci_wide_w = (idx_w == IORAT_IDX_SCI) && (req_size == IORAT_SZ_16);
  // spi data word at 32 bits; narrow accesses keep the region figure
  assign spi_wide_w = (idx_w == IORAT_IDX_SPI) && (req_size == IORAT_SZ_32) &&
                      ((req_addr[11:0] & IORAT_SPI_CH_MASK) == IORAT_SPI_DATA_OFS);
  assign wide_extra_w = (sci_wide_w || spi_wide_w) ? IORAT_WIDE_EXTRA : 6'h00;
  assign load_w = base_w + port_extra_w + wide_extra_w;

  //////////////////////////////////////////////////////////////////////////////
  // state and counters
  iorat_state_t state_r;
  iorat_state_t state_nxt;
  logic [5:0] cnt_r;
  logic [5:0] cnt_nxt;
  logic [1:0] unit_r;
  logic qspi_r;
  logic err_r;
  logic unit_tick_w;
  logic last_w;
  logic take_w;

  assign take_w = (state_r == IORAT_ST_IDLE) && req_valid;
  assign unit_tick_w = tick_w[unit_r];
  // only whole reference-clock edges are counted: the first edge lands anywhere in
  // the first period, so the elapsed time falls between count-1 and count periods
  // and never below one peripheral cycle
  // contention from fetches or other masters freezes the count
  assign last_w = unit_tick_w && !contend && (cnt_r == 6'h01);

  // next state
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    case (state_r)
      IORAT_ST_IDLE: begin
        if (take_w) begin
          // unassigned addresses are answered at once with an error
          state_nxt = mapped_w ? IORAT_ST_COUNT : IORAT_ST_DONE;
          cnt_nxt = load_w;
        end
      end
      IORAT_ST_COUNT: begin
        // clock b regions clock a flash clock
        if (unit_tick_w && !contend) begin
          cnt_nxt = cnt_r - 6'h01;
        end
        if (last_w) begin
          // quad spi keeps stalling for its serial bus after the minimum
          state_nxt = (qspi_r && !qspi_done) ? IORAT_ST_QWAIT : IORAT_ST_DONE;
        end
      end
      IORAT_ST_QWAIT: begin
        if (qspi_done) begin
          state_nxt = IORAT_ST_DONE;
        end
      end
      IORAT_ST_DONE: begin
        state_nxt = IORAT_ST_IDLE;
      end
      default: begin
        state_nxt = IORAT_ST_IDLE;
      end
    endcase
  end

  // state registers and latched request attributes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= IORAT_ST_IDLE;
      cnt_r <= '0;
      unit_r <= IORAT_U_CORE;
      qspi_r <= 1'b0;
      err_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      if (take_w) begin
        unit_r <= mapped_w ? IORAT_UNIT[idx_w] : IORAT_U_CORE;
        qspi_r <= mapped_w && IORAT_QSPI[idx_w];
        err_r <= !mapped_w;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // peripheral side: select held for the whole access
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      periph_sel_r <= 1'b0;
      periph_write_r <= 1'b0;
      periph_addr_r <= '0;
      periph_size_r <= IORAT_SZ_8;
      periph_wdata_r <= '0;
    end else begin
      periph_sel_r <= (state_nxt == IORAT_ST_COUNT) || (state_nxt == IORAT_ST_QWAIT);
      if (take_w && mapped_w) begin
        periph_write_r <= req_write;
        periph_addr_r <= req_addr;
        periph_size_r <= req_size;
        periph_wdata_r <= req_wdata;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // master side: busy while stalled, then one completion cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      resp_valid_r <= 1'b0;
      resp_err_r <= 1'b0;
      resp_rdata_r <= '0;
      busy_r <= 1'b0;
    end else begin
      resp_valid_r <= (state_nxt == IORAT_ST_DONE);
      busy_r <= (state_nxt == IORAT_ST_COUNT) || (state_nxt == IORAT_ST_QWAIT);
      resp_err_r <= (state_nxt == IORAT_ST_DONE) && (take_w ? !mapped_w : err_r);
      if (state_nxt == IORAT_ST_DONE) begin
        // reads capture peripheral data; writes and errors return zero
        resp_rdata_r <= (periph_write_r || err_r || take_w) ? '0 : periph_rdata;
      end
    end
  end

endmodule

// file: iorat_bridge_monitor.sv
// iorat_bridge_monitor: latency and completion assertions on the bridge ports
// assumes: bound into iorat_bridge; ratios and wait count stay put during an access
`timescale 1ns/1ns
module iorat_bridge_monitor
  import iorat_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic contend,
  input wire logic [IORAT_RW-1:0] peripheral_clock_a_ratio,
  input wire logic [IORAT_RW-1:0] peripheral_clock_b_ratio,
  input wire logic [IORAT_WW-1:0] port_read_wait_count,
  input wire logic resp_valid_r,
  input wire logic resp_err_r,
  input wire logic busy_r,
  input wire logic periph_write_r,
  input wire logic [IORAT_AW-1:0] periph_addr_r,
  input wire logic [1:0] periph_size_r
);
  logic [5:0] bcnt_r;
  logic [5:0] ccnt_r;
  logic [31:0] a_r;
  logic w_r;
  logic [1:0] s_r;
  // latency without contention, and what the finished access was
  wire [5:0] lat = bcnt_r - ccnt_r;
  wire rd_end = resp_valid_r && !resp_err_r && !w_r;
  wire ctrl = periph_addr_r <= 32'h4000_6fff;
  wire pa1 = peripheral_clock_a_ratio == IORAT_RATIO_ONE;
  wire pb1 = peripheral_clock_b_ratio == IORAT_RATIO_ONE;
  wire spi_dat = (a_r[11:0] & IORAT_SPI_CH_MASK) == IORAT_SPI_DATA_OFS;
  wire [5:0] port_lat = 6'h05 + {3'h0, port_read_wait_count};

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  // count busy and contended cycles of the running access
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bcnt_r <= 6'h00;
      ccnt_r <= 6'h00;
      a_r <= 32'h0;
      w_r <= 1'b0;
      s_r <= 2'h0;
    end else if (busy_r) begin
      bcnt_r <= bcnt_r + 6'h01;
      ccnt_r <= ccnt_r + {5'h00, contend};
      a_r <= periph_addr_r;
      w_r <= periph_write_r;
      s_r <= periph_size_r;
    end else begin
      bcnt_r <= 6'h00;
      ccnt_r <= 6'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  resp_pulse_a: assert property (resp_valid_r |=> !resp_valid_r)
    else $error("completion longer than one cycle");
  err_timing_a: assert property (resp_err_r |-> resp_valid_r && !$past(busy_r))
    else $error("unmapped answer not immediate");
  ctrl_read_a: assert property ($rose(busy_r) && ctrl && !periph_write_r && !contend
    |-> busy_r[*4] ##1 (resp_valid_r && !busy_r)) else $error("control read length wrong");
  ctrl_write_a: assert property ($rose(busy_r) && ctrl && periph_write_r && !contend
    |-> busy_r[*3] ##1 (resp_valid_r && !busy_r)) else $error("control write length wrong");
  port_wait_a: assert property (rd_end && a_r >= IORAT_PFS_LO && a_r <= IORAT_PFS_HI
    |-> lat == port_lat) else $error("pin function read length wrong");
  sci_wide_a: assert property (rd_end && a_r[31:12] == 20'h40118 && s_r == IORAT_SZ_16
    && pa1 |-> lat == 6'h07) else $error("wide serial read length wrong");
  spi_word_a: assert property (rd_end && a_r[31:12] == 20'h4011a && spi_dat
    && s_r == IORAT_SZ_32 && pa1 |-> lat == 6'h07) else $error("spi word read length wrong");
  timer_b_a: assert property (rd_end && a_r[31:12] == 20'h400e8 && pb1
    |-> lat == 6'h07) else $error("async timer read length wrong");
  pwm_a_a: assert property (rd_end && a_r[31:12] == 20'h40169 && pa1
    |-> lat == 6'h07) else $error("pwm timer read length wrong");

  cover property (resp_err_r);
  cover property (busy_r && contend);
  cover property (rd_end && lat > 6'h19);
endmodule

bind iorat_bridge iorat_bridge_monitor mon_u (
  .clk(clk), .rst_n(rst_n), .contend(contend),
  .peripheral_clock_a_ratio(peripheral_clock_a_ratio),
  .peripheral_clock_b_ratio(peripheral_clock_b_ratio),
  .port_read_wait_count(port_read_wait_count),
  .resp_valid_r(resp_valid_r), .resp_err_r(resp_err_r), .busy_r(busy_r),
  .periph_write_r(periph_write_r), .periph_addr_r(periph_addr_r),
  .periph_size_r(periph_size_r)
);

// file: iorat_periph_model.sv
// iorat_periph_model: peripheral side of the bridge, read data and serial finish
// assumes: the bridge holds periph_sel_r for the whole access
`timescale 1ns/1ns
module iorat_periph_model
  import iorat_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] done_delay,
  input wire logic periph_sel_r,
  input wire logic periph_write_r,
  input wire logic [IORAT_AW-1:0] periph_addr_r,
  output logic [IORAT_DW-1:0] periph_rdata,
  output logic qspi_done
);
  logic [7:0] sel_cnt_r;
  logic [31:0] junk_r;
  // age of the current access; filler that changes every cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sel_cnt_r <= 8'h00;
      junk_r <= 32'h0000_0001;
    end else begin
      sel_cnt_r <= periph_sel_r ? sel_cnt_r + 8'h01 : 8'h00;
      junk_r <= {junk_r[30:0], ~junk_r[31]};
    end
  end
  // data only while a read is selected, filler otherwise
  assign periph_rdata = (periph_sel_r && !periph_write_r) ? periph_addr_r ^ 32'h5a5a_a5a5 : junk_r;
  assign qspi_done = periph_sel_r && (sel_cnt_r >= done_delay);
endmodule

// file: io_register_access_timing_tb_top.sv
// io_register_access_timing_tb_top: directed latency tests of the bridge
// assumes: iorat_periph_model answers reads and serial completion
`timescale 1ns/1ns
module io_register_access_timing_tb_top
  import iorat_pkg::*;
;
  logic clk;
  logic rst_n;
  logic req_valid;
  logic req_write;
  logic [31:0] req_addr;
  logic [1:0] req_size;
  logic contend;
  logic [3:0] ratio;
  logic [2:0] wcnt;
  logic [7:0] qdly;
  logic qspi_done;
  logic [31:0] periph_rdata;
  logic resp_valid_r;
  logic resp_err_r;
  logic [31:0] resp_rdata_r;
  logic busy_r;
  logic periph_sel_r;
  logic periph_write_r;
  logic [31:0] periph_addr_r;
  logic [31:0] periph_wdata_r;
  int fail_count = 0;
  int n_checks = 0;

  iorat_bridge dut_u (
    .clk(clk), .rst_n(rst_n), .req_valid(req_valid), .req_write(req_write),
    .req_addr(req_addr), .req_size(req_size), .req_wdata(~req_addr), .contend(contend),
    .peripheral_clock_a_ratio(ratio), .peripheral_clock_b_ratio(ratio),
    .flash_clock_ratio(ratio),
    .port_read_wait_count(wcnt), .qspi_done(qspi_done), .periph_rdata(periph_rdata),
    .resp_valid_r(resp_valid_r), .resp_err_r(resp_err_r), .resp_rdata_r(resp_rdata_r),
    .busy_r(busy_r), .periph_sel_r(periph_sel_r), .periph_write_r(periph_write_r),
    .periph_addr_r(periph_addr_r), .periph_size_r(), .periph_wdata_r(periph_wdata_r)
  );
  iorat_periph_model peri_u (
    .clk(clk), .rst_n(rst_n), .done_delay(qdly), .periph_sel_r(periph_sel_r),
    .periph_write_r(periph_write_r), .periph_addr_r(periph_addr_r),
    .periph_rdata(periph_rdata), .qspi_done(qspi_done)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // range compare, unknown never matches
  task automatic chk(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
    n_checks++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h..%h", $time, got, lo, hi);
    end
  endtask

  // one access held until completion; cycles from the taking edge to the
  // completion cycle, both counted
  task automatic acc(input logic [31:0] a, input logic w, input logic [1:0] s,
                     input logic e, input int lo, input int hi);
    int n;
    logic [31:0] d;
    n = 0;
    d = (w || e) ? 32'h0 : a ^ 32'h5a5a_a5a5;
    @(negedge clk);
    req_valid = 1'b1;
    req_write = w;
    req_addr = a;
    req_size = s;
    do begin
      @(negedge clk);
      n++;
    end while (resp_valid_r !== 1'b1 && n < 300);
    req_valid = 1'b0;
    chk(32'(n), 32'(lo), 32'(hi));
    chk({31'h0, resp_err_r}, {31'h0, e}, {31'h0, e});
    chk(resp_rdata_r, d, d);
    // write data handed on to the peripheral unchanged
    if (w && !e) begin
      chk(periph_wdata_r, ~a, ~a);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // core clocked regions and port wait count
  task automatic t_core;
    acc(32'h4000_0000, 1'b0, IORAT_SZ_32, 1'b0, 5, 5);
    acc(32'h4000_6ffc, 1'b1, IORAT_SZ_32, 1'b0, 4, 4);
    acc(32'h4001_f000, 1'b0, IORAT_SZ_8, 1'b0, 6, 6);
    acc(32'h4001_f000, 1'b1, IORAT_SZ_8, 1'b0, 5, 5);
    for (int w = 0; w < 8; w += 7) begin
      wcnt = 3'(w);
      acc(32'h4001_f800, 1'b0, IORAT_SZ_32, 1'b0, 6 + w, 6 + w);
      acc(32'h4001_f0f8, 1'b0, IORAT_SZ_32, 1'b0, 6 + w, 6 + w);
    end
    wcnt = 3'h0;
    $display("test core done");
  endtask

  // divided clock regions at core to unit ratio n
  task automatic t_units(input int n);
    logic [31:0] ad [4];
    int lr [4];
    ad = '{32'h4008_2000, 32'h400e_8000, 32'h4016_9000, 32'h407e_c000};
    lr = '{5, 7, 7, 5};
    ratio = 4'(n);
    for (int i = 0; i < 4; i++) begin
      acc(ad[i], 1'b0, IORAT_SZ_32, 1'b0, (lr[i] - 1) * n + 2, lr[i] * n + 1);
      acc(ad[i], 1'b1, IORAT_SZ_32, 1'b0, 3 * n + 2, 4 * n + 1);
    end
    ratio = 4'h1;
    $display("test units ratio %0d done", n);
  endtask

  // size dependent extras in the serial regions
  task automatic t_width;
    acc(32'h4011_8000, 1'b0, IORAT_SZ_16, 1'b0, 8, 8);
    acc(32'h4011_8000, 1'b1, IORAT_SZ_16, 1'b0, 7, 7);
    acc(32'h4011_8001, 1'b0, IORAT_SZ_8, 1'b0, 6, 6);
    acc(32'h4011_a004, 1'b0, IORAT_SZ_32, 1'b0, 8, 8);
    acc(32'h4011_a004, 1'b0, IORAT_SZ_16, 1'b0, 6, 6);
    acc(32'h4011_a104, 1'b1, IORAT_SZ_32, 1'b0, 7, 7);
    $display("test width done");
  endtask

  // three contended cycles stretch a port read
  task automatic t_contend;
    fork
      acc(32'h4001_f000, 1'b0, IORAT_SZ_8, 1'b0, 9, 9);
      begin
        repeat (2) @(negedge clk);
        contend = 1'b1;
        repeat (3) @(negedge clk);
        contend = 1'b0;
      end
    join
    $display("test contend done");
  endtask

  // serial data window, prompt and slow engine, then an unmapped hole
  task automatic t_qspi_hole;
    qdly = 8'h05;
    acc(32'h6400_0010, 1'b0, IORAT_SZ_32, 1'b0, 26, 27);
    qdly = 8'h28;
    acc(32'h6400_0010, 1'b0, IORAT_SZ_32, 1'b0, 41, 43);
    acc(32'h4001_d000, 1'b0, IORAT_SZ_32, 1'b1, 1, 1);
    acc(32'h4000_0004, 1'b0, IORAT_SZ_32, 1'b0, 5, 5);
    $display("test qspi and hole done");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // 50 MHz core clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // watchdog well past the roughly 500 cycles of the run
  initial begin
    #100000;
    fail_count++;
    final_report();
  end

  // reset, then the scenarios
  initial begin
    rst_n = 1'b0;
    req_valid = 1'b0;
    req_write = 1'b0;
    req_addr = 32'h0;
    req_size = IORAT_SZ_32;
    contend = 1'b0;
    ratio = 4'h1;
    wcnt = 3'h0;
    qdly = 8'h05;
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    t_core();
    t_units(1);
    t_units(2);
    t_units(3);
    t_width();
    t_contend();
    t_qspi_hole();
    final_report();
  end
endmodule
